// ---- shared/nbb_pkg.sv ----
`default_nettype none
// ---------------------------------------------------------------------------
// Shared constants and types of the flash host controller.
// ---------------------------------------------------------------------------
package nbb_pkg;

  // ---------------------------------------------------------------------------
  // Opcodes that the controller issues.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OPC_READ     = 8'h00;  // Page read, first cycle.
  localparam logic [7:0] OPC_READ_GO  = 8'h30;  // Page read, confirm.
  localparam logic [7:0] OPC_PROG     = 8'h80;  // Page program, first cycle.
  localparam logic [7:0] OPC_PROG_GO  = 8'h10;  // Page program, confirm.
  localparam logic [7:0] OPC_ERASE    = 8'h60;  // Block erase, first cycle.
  localparam logic [7:0] OPC_ERASE_GO = 8'hd0;  // Block erase, confirm.

  // ---------------------------------------------------------------------------
  // Timing: settle time before the busy line is trusted.
  // ---------------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS   = 4;    // 250 MHz system clock.
  localparam int         BUSY_SETTLE_NS  = 100;  // Least wait before ready is sampled.
  localparam int         BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_LAST     = 8'(BUSY_SETTLE_CYC - 1);

  // ---------------------------------------------------------------------------
  // Addressing and defect marker layout.
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  ADDR_LAST      = 3'h4;    // Fifth address cycle.
  localparam logic [2:0]  ROW_FIRST      = 3'h2;    // First row cycle (erase).
  localparam logic [5:0]  LAST_PAGE      = 6'h3f;   // Last page of a block.
  localparam logic [11:0] SPARE_COL_X8   = 12'h800; // First spare byte, byte-wide.
  localparam logic [11:0] SPARE_COL_X16  = 12'h400; // First spare word, word-wide.
  localparam logic [7:0]  MARK_GOOD      = 8'hff;   // Marker of a good block.
  localparam logic [3:0]  MARK_MAJORITY  = 4'h5;    // Zero bits that mean defective.
  localparam logic [1:0]  SCAN_LAST_STEP = 2'h3;    // Four marker reads per block.

  // ---------------------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_PROG  = 2'b01,
    OP_ERASE = 2'b10
  } nbb_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_WDATA = 3'b011,
    ST_CONF  = 3'b100,
    ST_WAIT  = 3'b101,
    ST_RDATA = 3'b110,
    ST_DONE  = 3'b111
  } nbb_state_t;

  // One request from the user side.
  typedef struct packed {
    nbb_op_t     op;
    logic [13:0] block;
    logic [5:0]  page;
    logic [11:0] col;
    logic [11:0] len;
  } nbb_req_t;

  // Control strobes toward the flash.
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
  } nbb_ctl_t;

endpackage
`default_nettype wire

// ---- logic/nbb_fifo.sv ----
`default_nettype none
// ---------------------------------------------------------------------------
// Synchronous FIFO with valid/ready on both sides.
// ---------------------------------------------------------------------------
module nbb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
  logic [AW:0]      wr_ptr;       // Write pointer with wrap bit.
  logic [AW:0]      rd_ptr;       // Read pointer with wrap bit.
  wire              push;
  wire              pop;

  // Full when the pointers differ only in the wrap bit.
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Pointers advance on each accepted word.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // Storage is not reset; empty slots are never shown.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule // nbb_fifo
`default_nettype wire

// ---- logic/nbb_host.sv ----
// Behaviour
// - CLE high latches command on write rise
// - ALE high latches address on write rise
// - Read strobe toggles out each data word
// - Low eight lines carry commands, addresses, data
// - High eight lines carry only data
// - Byte-wide: five cycles, 12-bit column, low first
// - Page, block, plane, unit bit positions fixed
// - Byte-wide unit bits low by density
// - Word-wide: 11-bit column, same row bits
// - Word-wide unit bits low by density
// - Never program or erase marked blocks
// - Read first and last page markers first
// - Majority of zero bits means defective
`default_nettype none
module nbb_host
  import nbb_pkg::*;
#(
  parameter bit WIDE       = 1'b0,  // 1 for the word-wide part.
  parameter int NUM_BLOCKS = 4096,  // Blocks of the attached density.
  parameter int TICK_DIV   = 4,     // System cycles per strobe half.
  parameter int FIFO_DEPTH = 8      // Read data buffer depth.
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST,
  // User request port.
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire nbb_req_t    REQ,
  output logic             DONE,
  output logic             REFUSED,
  // Program data stream.
  input  wire logic        WR_VALID,
  output logic             WR_READY,
  input  wire logic [15:0] WR_DATA,
  // Read data stream.
  output logic             RD_VALID,
  input  wire logic        RD_READY,
  output logic [15:0]      RD_DATA,
  // Defect scan state.
  output logic             SCAN_DONE,
  output logic [14:0]      BAD_COUNT,
  // Flash pins.
  output nbb_ctl_t         NAND_CTL,
  output logic [15:0]      NAND_IO_OUT,
  output logic             NAND_IO_OE_LO,
  output logic             NAND_IO_OE_HI,
  input  wire logic [15:0] NAND_IO_IN,
  input  wire logic        NAND_RB_N
);
  // ---------------------------------------------------------------------------
  // Constants and decode functions.
  // ---------------------------------------------------------------------------
  localparam int         BLK_W     = $clog2(NUM_BLOCKS);
  localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);
  localparam logic [13:0] BLK_LAST = 14'(NUM_BLOCKS - 1);

  // First opcode of each operation.
  function automatic logic [7:0] op_first(input nbb_op_t op);
    case (op)
      OP_PROG:  return OPC_PROG;
      OP_ERASE: return OPC_ERASE;
      default:  return OPC_READ;
    endcase
  endfunction

  // Confirm opcode of each operation.
  function automatic logic [7:0] op_conf(input nbb_op_t op);
    case (op)
      OP_PROG:  return OPC_PROG_GO;
      OP_ERASE: return OPC_ERASE_GO;
      default:  return OPC_READ_GO;
    endcase
  endfunction

  // Forces unused unit bits low so a smaller part never sees them.
  function automatic logic [13:0] clamp_block(input logic [13:0] b);
    logic [13:0] r;
    r = b;
    if (NUM_BLOCKS <= 4096) begin
      r[13:12] = 2'h0;
    end else if (NUM_BLOCKS <= 8192) begin
      r[13] = 1'b0;
    end
    return r;
  endfunction

  // Byte of one address cycle; the row layout is the same for both widths.
  function automatic logic [7:0] addr_cycle(input logic [2:0] idx,
                                            input logic [11:0] col,
                                            input logic [19:0] row);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      3'h0: b = col[7:0];
      3'h1: b = WIDE ? {5'h00, col[10:8]} : {4'h0, col[11:8]};
      3'h2: b = row[7:0];
      3'h3: b = row[15:8];
      default: b = {4'h0, row[19:16]};
    endcase
    return b;
  endfunction

  // Counts the zero bits of a marker byte.
  function automatic logic [3:0] zero_count(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, ~v[i]};
    end
    return n;
  endfunction

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  nbb_state_t  state;        // Bus sequencer state.
  nbb_req_t    cur;          // Operation in flight.
  logic [7:0]  tick_cnt;     // Strobe rate divider.
  logic        half;         // Second half of a strobe cycle.
  logic [2:0]  addr_idx;     // Current address cycle.
  logic [11:0] word_cnt;     // Data words moved so far.
  logic [7:0]  settle_cnt;   // Cycles since the confirm opcode.
  logic        scan_active;  // Defect scan in progress.
  logic [13:0] scan_blk;     // Block under scan.
  logic [1:0]  scan_step;    // Which marker of the block is read.
  logic        scan_bad;     // Any marker of this block was defective.
  logic        bad_tbl [NUM_BLOCKS];  // One flag per block.

  // ---------------------------------------------------------------------------
  // Decoding.
  // ---------------------------------------------------------------------------
  wire         tick      = (tick_cnt == TICK_LAST);
  wire [11:0]  spare_col = WIDE ? SPARE_COL_X16 : SPARE_COL_X8;
  wire [19:0]  row       = {clamp_block(cur.block), cur.page};
  wire [7:0]   addr_byte = addr_cycle(addr_idx, cur.col, row);
  wire         is_cmd    = (state == ST_CMD) || (state == ST_CONF);
  wire         is_addr   = (state == ST_ADDR);
  wire         is_wdata  = (state == ST_WDATA);
  wire         wr_phase  = is_cmd || is_addr || is_wdata;
  wire         last_word = (word_cnt == cur.len - 12'h001);
  wire         fifo_in_ready;
  wire         rd_push;
  wire         rd_sink_ok;
  wire         req_bad;
  wire         marker_bad;
  wire [15:0]  wr_word;
  wire [15:0]  rd_word;
  nbb_req_t    scan_req;

  assign scan_req.op    = OP_READ;
  assign scan_req.block = scan_blk;
  assign scan_req.page  = scan_step[1] ? LAST_PAGE : 6'h00;
  assign scan_req.col   = scan_step[0] ? spare_col : 12'h000;
  assign scan_req.len   = 12'h001;

  assign req_bad = (REQ.op != OP_READ) &&
                   ((REQ.block > BLK_LAST) || bad_tbl[REQ.block[BLK_W-1:0]]);

  assign marker_bad = (zero_count(NAND_IO_IN[7:0]) >= MARK_MAJORITY);

  assign wr_word = is_wdata ? (WIDE ? WR_DATA : {8'h00, WR_DATA[7:0]})
                            : {8'h00, (is_cmd ? (state == ST_CMD ? op_first(cur.op)
                                                                 : op_conf(cur.op))
                                              : addr_byte)};
  assign rd_word = WIDE ? NAND_IO_IN : {8'h00, NAND_IO_IN[7:0]};

  // Read data goes to the scan check or to the buffer, which may stall.
  assign rd_sink_ok = scan_active || fifo_in_ready;
  assign rd_push    = tick && (state == ST_RDATA) && half && !scan_active;

  assign REQ_READY = (state == ST_IDLE) && SCAN_DONE && !scan_active;
  assign WR_READY  = tick && is_wdata && !half;

  // ---------------------------------------------------------------------------
  // Strobe rate divider.
  // ---------------------------------------------------------------------------
  // Every strobe half lasts at least TICK_DIV cycles, which sets the shortest bus cycle time.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus sequencer.
  // ---------------------------------------------------------------------------
  // One write cycle is a low half and a high half of the write strobe; the
  // latch enables and data change only as the strobe falls, or one cycle
  // after its last rise, so they are stable around its rising edge.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state         <= ST_IDLE;
      cur           <= '0;
      half          <= 1'b0;
      addr_idx      <= 3'h0;
      word_cnt      <= 12'h000;
      settle_cnt    <= 8'h00;
      NAND_CTL      <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};
      NAND_IO_OUT   <= 16'h0000;
      NAND_IO_OE_LO <= 1'b0;
      NAND_IO_OE_HI <= 1'b0;
      DONE          <= 1'b0;
      REFUSED       <= 1'b0;
      scan_active   <= 1'b1;
      SCAN_DONE     <= 1'b0;
      scan_blk      <= 14'h0000;
      scan_step     <= 2'h0;
      scan_bad      <= 1'b0;
      BAD_COUNT     <= 15'h0000;
    end else begin
      DONE <= 1'b0;
      case (state)
        // Idle: the scan has priority, then user requests.
        ST_IDLE: begin
          if (scan_active || (REQ_VALID && REQ_READY && !req_bad)) begin
            cur           <= scan_active ? scan_req : REQ;
            NAND_CTL.ce_n <= 1'b0;
            NAND_CTL.wp_n <= !scan_active && (REQ.op != OP_READ);
            addr_idx      <= (!scan_active && REQ.op == OP_ERASE) ? ROW_FIRST : 3'h0;
            word_cnt      <= 12'h000;
            half          <= 1'b0;
            state         <= ST_CMD;
          end else if (REQ_VALID && REQ_READY) begin
            // A program or erase of a marked or absent block ends at once, nothing on the pins.
            DONE    <= 1'b1;
            REFUSED <= 1'b1;
          end
        end
        // Command, address and program data share one write cycle.
        ST_CMD, ST_ADDR, ST_WDATA, ST_CONF: begin
          if (tick && (!is_wdata || WR_VALID || half)) begin
            if (!half) begin
              NAND_CTL.cle  <= is_cmd;
              NAND_CTL.ale  <= is_addr;
              NAND_CTL.we_n <= 1'b0;
              NAND_IO_OUT   <= wr_word;
              NAND_IO_OE_LO <= 1'b1;
              NAND_IO_OE_HI <= is_wdata && WIDE;
              half          <= 1'b1;
            end else begin
              NAND_CTL.we_n <= 1'b1;
              half          <= 1'b0;
              case (state)
                ST_CMD: begin
                  state <= ST_ADDR;
                end
                ST_ADDR: begin
                  addr_idx <= addr_idx + 3'h1;
                  if (addr_idx == ADDR_LAST) begin
                    state <= (cur.op == OP_PROG) ? ST_WDATA : ST_CONF;
                  end
                end
                ST_WDATA: begin
                  word_cnt <= word_cnt + 12'h001;
                  if (last_word) begin
                    state <= ST_CONF;
                  end
                end
                default: begin
                  settle_cnt <= 8'h00;
                  state      <= ST_WAIT;
                end
              endcase
            end
          end
        end
        // Wait out the settle time, then for the busy line to release.
        ST_WAIT: begin
          NAND_CTL.cle  <= 1'b0;
          NAND_CTL.ale  <= 1'b0;
          NAND_IO_OE_LO <= 1'b0;
          NAND_IO_OE_HI <= 1'b0;
          if (settle_cnt != SETTLE_LAST) begin
            settle_cnt <= settle_cnt + 8'h01;
          end else if (NAND_RB_N) begin
            word_cnt <= 12'h000;
            half     <= 1'b0;
            state    <= (cur.op == OP_READ) ? ST_RDATA : ST_DONE;
          end
        end
        // Each read strobe cycle brings one word out of the device.
        ST_RDATA: begin
          if (tick && (half || rd_sink_ok)) begin
            if (!half) begin
              NAND_CTL.re_n <= 1'b0;
              half          <= 1'b1;
            end else begin
              NAND_CTL.re_n <= 1'b1;
              half          <= 1'b0;
              word_cnt      <= word_cnt + 12'h001;
              if (scan_active && marker_bad) begin
                scan_bad <= 1'b1;
              end
              if (last_word) begin
                state <= ST_DONE;
              end
            end
          end
        end
        // Release the device and report or advance the scan.
        ST_DONE: begin
          NAND_CTL.ce_n <= 1'b1;
          NAND_CTL.wp_n <= 1'b0;
          state         <= ST_IDLE;
          if (!scan_active) begin
            DONE    <= 1'b1;
            REFUSED <= 1'b0;
          end else begin
            scan_step <= scan_step + 2'h1;
            if (scan_step == SCAN_LAST_STEP) begin
              scan_bad  <= 1'b0;
              BAD_COUNT <= BAD_COUNT + {14'h0000, scan_bad};
              if (scan_blk == BLK_LAST) begin
                scan_active <= 1'b0;
                SCAN_DONE   <= 1'b1;
              end else begin
                scan_blk <= scan_blk + 14'h0001;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Defect table.
  // ---------------------------------------------------------------------------
  // The table is only trusted once the scan is done, so it needs no reset.
  always_ff @(posedge CLK) begin
    if (state == ST_DONE && scan_active && scan_step == SCAN_LAST_STEP) begin
      bad_tbl[scan_blk[BLK_W-1:0]] <= scan_bad;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data buffer.
  // ---------------------------------------------------------------------------
  // A full buffer holds the read strobe high, so a slow reader stalls the bus.
  nbb_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_rd_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (rd_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rd_word),
    .out_valid (RD_VALID),
    .out_ready (RD_READY),
    .out_data  (RD_DATA)
  );
endmodule // nbb_host
`default_nettype wire

// ---- testbench/nbb_host_checker.sv ----
`default_nettype none
// ----------------------------------------
// Pin checker of the flash host.
// ----------------------------------------
module nbb_host_checker
  import nbb_pkg::*;
#(parameter bit WIDE = 1'b0, parameter int TICK_DIV = 4) (
  // Clock and user status.
  input wire logic     CLK,
  input wire logic     RST,
  input wire logic     DONE,
  input wire logic     REFUSED,
  input wire logic     SCAN_DONE,
  // Flash pins.
  input wire nbb_ctl_t NAND_CTL,
  input wire logic     NAND_IO_OE_LO,
  input wire logic     NAND_IO_OE_HI,
  input wire logic     NAND_RB_N
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cle, ale, ce_n, we_n, re_n, wp_n;  // Strobes taken apart.
  assign {cle, ale, ce_n, we_n, re_n, wp_n} = NAND_CTL;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_one_latch; !(cle && ale); endproperty
  a_one_latch: assert property (p_one_latch) else $error("cle with ale");
  property p_lo_drive; $rose(we_n) && (cle || ale) |-> NAND_IO_OE_LO; endproperty
  a_lo_drive: assert property (p_lo_drive) else $error("latch undriven");
  property p_we_width; $fell(we_n) |-> ##TICK_DIV $rose(we_n); endproperty
  a_we_width: assert property (p_we_width) else $error("strobe width");
  property p_re_float; !re_n |-> !NAND_IO_OE_LO && !NAND_IO_OE_HI; endproperty
  a_re_float: assert property (p_re_float) else $error("drive in read");
  property p_hi_data; NAND_IO_OE_HI |-> WIDE && !cle && !ale; endproperty
  a_hi_data: assert property (p_hi_data) else $error("high lines misused");
  property p_standby; DONE |-> ce_n; endproperty
  a_standby: assert property (p_standby) else $error("selected at done");
  property p_busy_quiet; !NAND_RB_N |-> we_n && re_n; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("strobe in busy");
  property p_scan_first; wp_n |-> SCAN_DONE; endproperty
  a_scan_first: assert property (p_scan_first) else $error("write before scan");
  property p_refuse; DONE && REFUSED |-> $past(ce_n) && !wp_n; endproperty
  a_refuse: assert property (p_refuse) else $error("refused op touched pins");
endmodule // nbb_host_checker
bind nbb_host nbb_host_checker #(.WIDE(WIDE), .TICK_DIV(TICK_DIV)) u_chk (.CLK(CLK),
  .RST(RST), .DONE(DONE), .REFUSED(REFUSED), .SCAN_DONE(SCAN_DONE), .NAND_CTL(NAND_CTL),
  .NAND_IO_OE_LO(NAND_IO_OE_LO), .NAND_IO_OE_HI(NAND_IO_OE_HI), .NAND_RB_N(NAND_RB_N));
`default_nettype wire

// ---- testbench/nbb_flash_model.sv ----
`default_nettype none
// ----------------------------------------
// Byte-wide flash device, behavioural.
// ----------------------------------------
module nbb_flash_model
  import nbb_pkg::*;
(
  // Clock, reset and pins.
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire nbb_ctl_t    ctl,
  input  wire logic [15:0] io_out,
  output logic [15:0]      io_in,
  output logic             rb_n,
  // Seen by the bench.
  output logic [39:0]      addr,
  output logic [7:0]       wdata,
  output logic [11:0]      n_data,
  output logic [7:0]       n_mod
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        prev_we, prev_re;  // Strobes one cycle back.
  logic [7:0]  busy, mark;        // Busy cycles left; marker byte.
  logic [11:0] col;               // Column of the next word.
  logic [15:0] last, word;        // Last word out; current word.
  logic        latch;             // Write strobe rise.
  // markers, one with only four zero bits.
  assign mark = (addr[35:22] == 14'h1) ? 8'h00 : (addr[35:22] == 14'h2) ? 8'h0f :
                (addr[35:22] == 14'h3 && addr[21:16] == LAST_PAGE) ? 8'h07 : MARK_GOOD;
  assign word = {8'h00, (col == 12'h000 || col == SPARE_COL_X8) ? mark : col[7:0] ^ 8'h5a};
  // read when selected; a released bus shows the inverse of the last word.
  assign io_in = (!ctl.re_n && !ctl.ce_n) ? word : ~last;
  assign rb_n = (busy == 8'h00);
  assign latch = !prev_we && ctl.we_n && !ctl.ce_n;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {prev_we, prev_re} <= 2'h3;
      busy <= 8'h00;
      n_mod <= 8'h00;
    end else begin
      prev_we <= ctl.we_n;
      prev_re <= ctl.re_n;
      busy <= (busy != 8'h00) ? busy - 8'h01 : 8'h00;
      if (!ctl.re_n) last <= word;
      if (!prev_re && ctl.re_n) col <= col + 12'h001;
      if (latch && ctl.cle) begin
        case (io_out[7:0])
          OPC_READ_GO: begin
            busy <= 8'h28;
            col <= addr[11:0];
          end
          OPC_PROG_GO, OPC_ERASE_GO: if (ctl.wp_n) begin
            busy <= 8'h28;
            n_mod <= n_mod + 8'h01;
          end
          OPC_PROG: n_data <= 12'h000;
          default: ;
        endcase
      end else if (latch && ctl.ale) begin
        addr <= {io_out[7:0], addr[39:8]};
      end else if (latch) begin
        n_data <= n_data + 12'h001;
        wdata <= io_out[7:0];
      end
    end
  end
endmodule // nbb_flash_model
`default_nettype wire

// ---- testbench/nbb_host_test.sv ----
`default_nettype none
module nbb_host_test
  import nbb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK, RST, REQ_VALID, REQ_READY, DONE, REFUSED, WR_VALID, WR_READY, stall;
  logic        RD_VALID, RD_READY, SCAN_DONE, NAND_IO_OE_LO, NAND_IO_OE_HI, NAND_RB_N;
  logic [15:0] WR_DATA, RD_DATA, NAND_IO_OUT, NAND_IO_IN, rdq[$], wq[$];
  logic [39:0] f_addr;
  logic [14:0] BAD_COUNT;
  logic [11:0] f_ndata, col;
  logic [7:0]  f_wdata, f_mod;
  logic        dq[$];
  nbb_req_t    REQ;
  nbb_ctl_t    NAND_CTL;
  int          n_errors, tests_run, n_done, seed, i;
  nbb_host #(.WIDE(1'b0), .NUM_BLOCKS(4), .TICK_DIV(2), .FIFO_DEPTH(8)) uut (.CLK, .RST,
    .REQ_VALID, .REQ_READY, .REQ, .DONE, .REFUSED, .WR_VALID, .WR_READY, .WR_DATA,
    .RD_VALID, .RD_READY, .RD_DATA, .SCAN_DONE, .BAD_COUNT, .NAND_CTL, .NAND_IO_OUT,
    .NAND_IO_OE_LO, .NAND_IO_OE_HI, .NAND_IO_IN, .NAND_RB_N);
  nbb_flash_model u_flash (.clk(CLK), .rst(RST), .ctl(NAND_CTL), .io_out(NAND_IO_OUT),
    .io_in(NAND_IO_IN), .rb_n(NAND_RB_N), .addr(f_addr), .wdata(f_wdata),
    .n_data(f_ndata), .n_mod(f_mod));
  task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
    tests_run++;
    if (exp !== got) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // A bounded wait that ran out ends the run.
  task automatic stuck(bit hung);
    if (hung) begin
      n_errors++;
      close_out();
    end
  endtask
  // Offers one request at a falling edge and waits for its done pulse.
  task automatic req(nbb_op_t op, logic [13:0] blk, logic [5:0] pg, logic [11:0] c,
                     logic [11:0] len, logic no);
    int t;
    t = n_done + 1;
    dq.push_back(no);
    REQ = '{op, blk, pg, c, len};
    REQ_VALID = 1'b1;
    for (i = 0; i < 5000 && REQ_READY !== 1'b1; i++) @(negedge CLK);
    stuck(REQ_READY !== 1'b1);
    @(negedge CLK);
    REQ_VALID = 1'b0;
    for (i = 0; i < 5000 && n_done < t; i++) @(negedge CLK);
    stuck(n_done < t);
  endtask
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // Inputs change at the falling edge; the far side stalls at random.
  always @(negedge CLK) begin
    RD_READY = !stall && ($random(seed) % 4 != 0);
    WR_VALID = (wq.size() > 0) && ($random(seed) % 2 != 0);
    WR_DATA = (wq.size() > 0) ? wq[0] : 16'h0000;
  end
  // Results are matched against the oldest note.
  always @(posedge CLK) begin
    if (RD_VALID && RD_READY) chk("read word", rdq.pop_front(), RD_DATA);
    if (DONE) begin
      chk("refused", dq.pop_front(), REFUSED);
      n_done++;
    end
    if (WR_VALID && WR_READY) void'(wq.pop_front());
  end
  initial begin
    seed = 32'h4b5cefcb;
    RST = 1'b1;
    REQ_VALID = 1'b0;
    REQ = '0;
    stall = 1'b0;
    {RD_READY, WR_VALID, WR_DATA} = '0;
    repeat (10) @(negedge CLK);
    RST = 1'b0;
    for (i = 0; i < 20000 && SCAN_DONE !== 1'b1; i++) @(negedge CLK);
    stuck(SCAN_DONE !== 1'b1);
    chk("bad blocks", 40'h2, BAD_COUNT);
    $display("scan test done");
    col = 12'h001 + 12'($random(seed) & 32'h1ff);
    for (i = 0; i < 12; i++) rdq.push_back({8'h00, 8'(col + 12'(i)) ^ 8'h5a});
    stall = 1'b1;
    fork
      req(OP_READ, 14'h2, 6'h05, col, 12'h00c, 1'b0);
      begin
        repeat (400) @(negedge CLK);
        stall = 1'b0;
      end
    join
    for (i = 0; i < 1000 && rdq.size() != 0; i++) @(negedge CLK);
    stuck(rdq.size() != 0);
    chk("read address", {16'h0000, 8'h85, 4'h0, col}, f_addr);
    $display("read test done");
    for (i = 0; i < 3; i++) wq.push_back(16'($random(seed)) & 16'h00ff);
    col = wq[2][11:0];
    req(OP_PROG, 14'h2, 6'h00, 12'h000, 12'h003, 1'b0);
    chk("data cycles", 40'h3, f_ndata);
    chk("last data", col, f_wdata);
    chk("array ops", 40'h1, f_mod);
    chk("program address", 40'h0000800000, f_addr);
    req(OP_PROG, 14'h1, 6'h00, 12'h000, 12'h001, 1'b1);
    req(OP_ERASE, 14'h3, 6'h00, 12'h000, 12'h001, 1'b1);
    req(OP_ERASE, 14'h4, 6'h00, 12'h000, 12'h001, 1'b1);
    req(OP_ERASE, 14'h2, 6'h00, 12'h000, 12'h001, 1'b0);
    chk("array ops", 40'h2, f_mod);
    chk("erase row", 24'h000080, f_addr[39:16]);
    $display("write test done");
    close_out();
  end
endmodule // nbb_host_test
`default_nettype wire
